/* File: hw/cer_regs.sv */
// control and status register bank of the crypto engine with read throttle and id map
`timescale 1ns/1ps
module cer_regs #(
   parameter int          CNT_W   = 8,
   parameter logic [47:0] SM_SIZE = 48'h0000_0000_8000
) (
   input  wire logic                       ref_clk,
   input  wire logic                       srst,
   input  wire logic [cer_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [31:0]                reg_rdata,
   input  wire logic                       eng_available,
   input  wire logic                       eng_stopped,
   input  wire logic                       dbg_halt_req,
   output logic                            dbg_halt_ack,
   output logic                            eng_soft_rst,
   output cer_pkg::cer_status_t            eng_status,
   input  wire cer_pkg::cer_dma_req_t      dma_req,
   output logic                            dma_to_secure,
   output logic                            dma_steer_valid,
   input  wire logic                       jr_rd_req,
   input  wire logic                       eng_rd_req,
   input  wire logic                       rd_burst_done,
   output logic                            jr_rd_gnt,
   output logic                            eng_rd_gnt,
   output logic                            jr_throttled,
   input  wire logic [cer_pkg::NUM_IDS-1:0] id_enable_pin,
   output logic      [3:0]                 jr_txn_id,
   output logic      [3:0]                 eng_txn_id
);

   //=======================================================================
   // helpers
   //=======================================================================
   // lowest enabled id strictly above a floor (floor -1 means from zero)
   function automatic logic [4:0] lowest_id(input logic [15:0] en, input int floor_id);
      logic [4:0] r;
      r = 5'h10;
      for (int i = cer_pkg::NUM_IDS - 1; i >= 0; i--)
      begin
         if (en[i] && (i > floor_id))
         begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // legacy offset of an address in either alias block
   function automatic logic [11:0] fold_alias(input logic [11:0] a);
      logic [11:0] r;
      r = a;
      if ((a >= cer_pkg::OFF_MAP_7_4 + cer_pkg::ALIAS_SHIFT) &&
          (a <= cer_pkg::OFF_ID_EN + cer_pkg::ALIAS_SHIFT))
      begin
         r = a - cer_pkg::ALIAS_SHIFT;
      end
      return r;
   endfunction

   //=======================================================================
   // state
   //=======================================================================
   logic                         poll_reg, poll_next;
   logic                         srst_bit_reg, srst_bit_next;
   logic                         halt_ack_reg, halt_ack_next;
   cer_pkg::cer_status_t         status_reg, status_next;
   logic [31:0]                  smb_reg [cer_pkg::NUM_RINGS];
   logic [31:0]                  smb_next [cer_pkg::NUM_RINGS];
   logic [cer_pkg::LIMIT_W-1:0]  limit_reg, limit_next;
   logic [31:0]                  rdata_reg, rdata_next;
   logic                         steer_reg, steer_next;
   logic                         steer_v_reg, steer_v_next;
   logic [CNT_W-1:0]             out_cnt_reg, out_cnt_next;
   logic                         jr_gnt_reg, jr_gnt_next;
   logic                         eng_gnt_reg, eng_gnt_next;
   logic                         thr_reg, thr_next;
   logic [15:0]                  en_meta_reg, en_reg;
   logic [3:0]                   jr_id_reg, jr_id_next;
   logic [3:0]                   eng_id_reg, eng_id_next;
   logic [7:0]                   bid [cer_pkg::NUM_IDS];
   logic [11:0]                  rd_off;
   logic [4:0]                   jr_lo, eng_lo;
   logic [47:0]                  sm_base;

   //=======================================================================
   // transaction id assignment and map
   //=======================================================================
   // job rings take the lowest enabled id, the engine the next one
   always_comb
   begin
      jr_lo  = lowest_id(en_reg, -1);
      eng_lo = lowest_id(en_reg, int'(jr_lo));
      for (int i = 0; i < cer_pkg::NUM_IDS; i++)
      begin
         bid[i] = cer_pkg::BID_NONE;
         if (en_reg[i] && (5'(i) == jr_lo))
         begin
            bid[i] = cer_pkg::BID_RING;
         end
         else if (en_reg[i] && (5'(i) == eng_lo))
         begin
            bid[i] = cer_pkg::BID_ENGINE;
         end
      end
      jr_id_next  = jr_lo[3:0];
      eng_id_next = eng_lo[3:0];
   end

   //=======================================================================
   // register file next state
   //=======================================================================
   always_comb
   begin
      poll_next     = poll_reg;
      srst_bit_next = 1'b0;
      status_next   = '{valid: 1'b0, code: cer_pkg::SRST_CODE};
      smb_next      = smb_reg;
      limit_next    = limit_reg;
      rdata_next    = 32'h0000_0000;
      rd_off        = fold_alias(reg_addr);
      // writes; writes to the availability register are ignored while halted
      if (reg_wr)
      begin
         unique case (reg_addr)
            cer_pkg::OFF_AVAIL:
            begin
               if (!dbg_halt_req && reg_wdata[cer_pkg::POLL_BIT])
               begin
                  poll_next = 1'b1;
               end
            end
            cer_pkg::OFF_SRST:
            begin
               if (reg_wdata[cer_pkg::SRST_BIT])
               begin
                  srst_bit_next = 1'b1;
                  status_next.valid = 1'b1;
               end
            end
            cer_pkg::OFF_SMB0: smb_next[0] = reg_wdata;
            cer_pkg::OFF_SMB1: smb_next[1] = reg_wdata;
            cer_pkg::OFF_SMB2: smb_next[2] = reg_wdata;
            cer_pkg::OFF_THROTTLE: limit_next = reg_wdata[cer_pkg::LIMIT_W-1:0];
            default: ;
         endcase
      end
      // the engine being available clears a pending poll
      if (eng_available)
      begin
         poll_next = 1'b0;
      end
      // reads, unmapped offsets and reserved bits answer zero
      if (reg_rd)
      begin
         unique case (rd_off)
            cer_pkg::OFF_AVAIL:
            begin
               rdata_next[0] = dbg_halt_req ? eng_stopped : poll_reg;
            end
            cer_pkg::OFF_SRST: rdata_next[0] = srst_bit_reg;
            cer_pkg::OFF_SMB0: rdata_next = smb_reg[0];
            cer_pkg::OFF_SMB1: rdata_next = smb_reg[1];
            cer_pkg::OFF_SMB2: rdata_next = smb_reg[2];
            cer_pkg::OFF_THROTTLE: rdata_next[cer_pkg::LIMIT_W-1:0] = limit_reg;
            cer_pkg::OFF_MAP_7_4:   rdata_next = {bid[7], bid[6], bid[5], bid[4]};
            cer_pkg::OFF_MAP_3_0:   rdata_next = {bid[3], bid[2], bid[1], bid[0]};
            cer_pkg::OFF_MAP_15_12: rdata_next = {bid[15], bid[14], bid[13], bid[12]};
            cer_pkg::OFF_MAP_11_8:  rdata_next = {bid[11], bid[10], bid[9], bid[8]};
            cer_pkg::OFF_ID_EN:     rdata_next = {16'h0000, en_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
      // acknowledge the halt only once the engine has stopped
      halt_ack_next = dbg_halt_req && eng_stopped;
   end

   //=======================================================================
   // secure memory steering
   //=======================================================================
   // window is the ring base with sixteen zero bits appended, spanning SM_SIZE
   always_comb
   begin
      sm_base      = 48'h0;
      steer_v_next = dma_req.valid;
      if (dma_req.ring < 2'(cer_pkg::NUM_RINGS))
      begin
         sm_base = {smb_reg[dma_req.ring], 16'h0000};
      end
      steer_next = dma_req.valid && (dma_req.ring < 2'(cer_pkg::NUM_RINGS)) &&
                   (dma_req.addr >= sm_base) &&
                   (dma_req.addr - sm_base < SM_SIZE);
   end

   //=======================================================================
   // read burst throttle and arbitration
   //=======================================================================
   always_comb
   begin
      out_cnt_next = out_cnt_reg;
      // limit zero never holds job rings back
      thr_next = (limit_reg != '0) &&
                 (out_cnt_reg > CNT_W'(limit_reg));
      eng_gnt_next = eng_rd_req;
      jr_gnt_next  = jr_rd_req && !eng_rd_req && !thr_next;
      if ((eng_gnt_reg || jr_gnt_reg) && !rd_burst_done)
      begin
         if (out_cnt_reg != '1)
         begin
            out_cnt_next = out_cnt_reg + 1'b1;
         end
      end
      else if (!(eng_gnt_reg || jr_gnt_reg) && rd_burst_done)
      begin
         if (out_cnt_reg != '0)
         begin
            out_cnt_next = out_cnt_reg - 1'b1;
         end
      end
   end

   //=======================================================================
   // registers
   //=======================================================================
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         poll_reg     <= 1'b0;
         srst_bit_reg <= 1'b0;
         halt_ack_reg <= 1'b0;
         status_reg   <= '{valid: 1'b0, code: cer_pkg::SRST_CODE};
         for (int i = 0; i < cer_pkg::NUM_RINGS; i++)
         begin
            smb_reg[i] <= cer_pkg::SMB_RST;
         end
         limit_reg    <= cer_pkg::LIMIT_RST;
         rdata_reg    <= 32'h0000_0000;
         steer_reg    <= 1'b0;
         steer_v_reg  <= 1'b0;
         out_cnt_reg  <= '0;
         jr_gnt_reg   <= 1'b0;
         eng_gnt_reg  <= 1'b0;
         thr_reg      <= 1'b0;
         en_meta_reg  <= 16'h0000;
         en_reg       <= 16'h0000;
         jr_id_reg    <= 4'h0;
         eng_id_reg   <= 4'h0;
      end
      else
      begin
         poll_reg     <= poll_next;
         srst_bit_reg <= srst_bit_next;
         halt_ack_reg <= halt_ack_next;
         status_reg   <= status_next;
         smb_reg      <= smb_next;
         limit_reg    <= limit_next;
         rdata_reg    <= rdata_next;
         steer_reg    <= steer_next;
         steer_v_reg  <= steer_v_next;
         out_cnt_reg  <= out_cnt_next;
         jr_gnt_reg   <= jr_gnt_next;
         eng_gnt_reg  <= eng_gnt_next;
         thr_reg      <= thr_next;
         en_meta_reg  <= id_enable_pin;   // two stage capture of strap pins
         en_reg       <= en_meta_reg;
         jr_id_reg    <= jr_id_next;
         eng_id_reg   <= eng_id_next;
      end
   end

   // outputs straight from flops
   assign reg_rdata       = rdata_reg;
   assign dbg_halt_ack    = halt_ack_reg;
   assign eng_soft_rst    = srst_bit_reg;
   assign eng_status      = status_reg;
   assign dma_to_secure   = steer_reg;
   assign dma_steer_valid = steer_v_reg;
   assign jr_rd_gnt       = jr_gnt_reg;
   assign eng_rd_gnt      = eng_gnt_reg;
   assign jr_throttled    = thr_reg;
   assign jr_txn_id       = jr_id_reg;
   assign eng_txn_id      = eng_id_reg;

   //=======================================================================
   // assertions
   //=======================================================================
   a_poll_clears: assert property (@(posedge ref_clk) disable iff (srst)
      eng_available |=> !poll_reg)
      else $error("poll bit not cleared while engine available");
   a_poll_sets: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_wr && reg_addr == cer_pkg::OFF_AVAIL && reg_wdata[0] && !dbg_halt_req &&
       !eng_available) |=> poll_reg)
      else $error("poll bit not armed by write");
   a_halt_frozen: assert property (@(posedge ref_clk) disable iff (srst)
      (dbg_halt_req && !eng_available) |=> (poll_reg == $past(poll_reg)))
      else $error("availability register changed during halt");
   a_halt_ack: assert property (@(posedge ref_clk) disable iff (srst)
      dbg_halt_ack |-> $past(dbg_halt_req && eng_stopped))
      else $error("halt acknowledged before engine stopped");
   a_srst_pulse: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_wr && reg_addr == cer_pkg::OFF_SRST && reg_wdata[0]) |=>
      (eng_soft_rst && eng_status.valid && eng_status.code == 8'h20) ##1 !eng_soft_rst)
      else $error("soft reset pulse or status wrong");
   a_srst_once: assert property (@(posedge ref_clk) disable iff (srst)
      eng_soft_rst |-> $past(reg_wr && reg_addr == cer_pkg::OFF_SRST))
      else $error("soft reset bit held without a write");
   a_secure_base: assert property (@(posedge ref_clk) disable iff (srst)
      (dma_req.valid && dma_req.ring == 2'd0 && dma_req.addr == {smb_reg[0], 16'h0000})
      |=> dma_to_secure)
      else $error("ring base address not steered to secure memory");
   a_below_base: assert property (@(posedge ref_clk) disable iff (srst)
      (dma_req.valid && dma_req.ring == 2'd0 && dma_req.addr < {smb_reg[0], 16'h0000})
      |=> !dma_to_secure)
      else $error("address below base steered to secure memory");
   a_throttle_block: assert property (@(posedge ref_clk) disable iff (srst)
      jr_rd_gnt |-> !$past(limit_reg != 7'h00 && out_cnt_reg > CNT_W'(limit_reg)))
      else $error("job ring read granted while throttled");
   a_engine_prio: assert property (@(posedge ref_clk) disable iff (srst)
      eng_rd_req |=> (eng_rd_gnt && !jr_rd_gnt))
      else $error("engine read not given priority");
   a_zero_limit: assert property (@(posedge ref_clk) disable iff (srst)
      (limit_reg == 7'h00) |=> !jr_throttled)
      else $error("throttle active with zero limit");
   a_id_unique: assert property (@(posedge ref_clk) disable iff (srst)
      ($countones(en_reg) >= 2) |=> (jr_txn_id < eng_txn_id))
      else $error("transaction ids not unique and ordered");
   a_map_disabled: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_rd && reg_addr == cer_pkg::OFF_MAP_3_0 && !en_reg[0]) |=> (reg_rdata[7:0] == 8'h00))
      else $error("disabled id reads non-zero");

endmodule

/* File: include/cer_pkg.sv */
// constants, field layouts and carrier types of the crypto engine control registers
//==========================================================================
//==========================================================================
package cer_pkg;
   localparam int ADDR_W = 12;
   // register byte offsets
   localparam logic [11:0] OFF_AVAIL     = 12'h120;
   localparam logic [11:0] OFF_SRST      = 12'h124;
   localparam logic [11:0] OFF_SMB0      = 12'h184;
   localparam logic [11:0] OFF_SMB1      = 12'h18c;
   localparam logic [11:0] OFF_SMB2      = 12'h194;
   localparam logic [11:0] OFF_THROTTLE  = 12'h220;
   localparam logic [11:0] OFF_MAP_7_4   = 12'h240;
   localparam logic [11:0] OFF_MAP_3_0   = 12'h244;
   localparam logic [11:0] OFF_MAP_15_12 = 12'h248;
   localparam logic [11:0] OFF_MAP_11_8  = 12'h24c;
   localparam logic [11:0] OFF_ID_EN     = 12'h250;
   // distance from the legacy block up to the preferred alias block
   localparam logic [11:0] ALIAS_SHIFT   = 12'h2c0;
   // field positions and widths
   localparam int POLL_BIT      = 0;
   localparam int SRST_BIT      = 0;
   localparam int LIMIT_W       = 7;
   localparam int SM_SHIFT      = 16;
   localparam int NUM_IDS       = 16;
   localparam int NUM_RINGS     = 3;
   // reset values
   localparam logic [31:0] SMB_RST   = 32'h0010_0000;
   localparam logic [6:0]  LIMIT_RST = 7'h00;
   // codes
   localparam logic [7:0]  BID_RING   = 8'h01;
   localparam logic [7:0]  BID_ENGINE = 8'h08;
   localparam logic [7:0]  BID_NONE   = 8'h00;
   localparam logic [7:0]  SRST_CODE  = 8'h20;

   // address presented by the dma for steering
   typedef struct packed {
      logic        valid;
      logic [1:0]  ring;
      logic [47:0] addr;
   } cer_dma_req_t;

   // job status written back after a soft engine reset
   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } cer_status_t;
endpackage

/* File: verif/cer_far_model.sv */
// far-side bus model that retires granted read bursts and can stall
`timescale 1ns/1ps
module cer_far_model (
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic jr_rd_gnt,
   input  wire logic eng_rd_gnt,
   input  wire logic stall,
   output logic      rd_burst_done
);
   int pend;
   //==========================================================================
   // bursts in flight; one retires every other cycle unless stalled
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         pend = 0;
         rd_burst_done <= 1'b0;
      end
      else
      begin
         pend = pend + int'(jr_rd_gnt) + int'(eng_rd_gnt) - int'(rd_burst_done);
         rd_burst_done <= !stall && !rd_burst_done && pend > 0;
      end
   end
endmodule

/* File: verif/cer_regs_tb_top.sv */
// self-checking testbench of the crypto engine control registers
`timescale 1ns/1ps
module cer_regs_tb_top;
   logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, eng_available = 0, eng_stopped = 0;
   logic dbg_halt_req = 0, jr_rd_req = 0, eng_rd_req = 0, stall = 0, rd_burst_done;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, rd_v, smb[3];
   logic [15:0] id_enable_pin = 16'h0;
   logic [31:0] reg_rdata;
   logic dbg_halt_ack, eng_soft_rst, dma_to_secure, dma_steer_valid, jr_rd_gnt, eng_rd_gnt;
   logic jr_throttled;
   logic [3:0] jr_txn_id, eng_txn_id;
   cer_pkg::cer_status_t eng_status;
   cer_pkg::cer_dma_req_t dma_req = '0;
   int err_total = 0, num_checks = 0, cyc = 0;
   localparam logic [11:0] ADR[3] = '{12'h184, 12'h18c, 12'h194};
   cer_regs DUT (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_available(eng_available),
      .eng_stopped(eng_stopped), .dbg_halt_req(dbg_halt_req), .dbg_halt_ack(dbg_halt_ack),
      .eng_soft_rst(eng_soft_rst), .eng_status(eng_status), .dma_req(dma_req),
      .dma_to_secure(dma_to_secure), .dma_steer_valid(dma_steer_valid), .jr_rd_req(jr_rd_req),
      .eng_rd_req(eng_rd_req), .rd_burst_done(rd_burst_done), .jr_rd_gnt(jr_rd_gnt),
      .eng_rd_gnt(eng_rd_gnt), .jr_throttled(jr_throttled), .id_enable_pin(id_enable_pin),
      .jr_txn_id(jr_txn_id), .eng_txn_id(eng_txn_id));
   cer_far_model FAR (.ref_clk(ref_clk), .srst(srst), .jr_rd_gnt(jr_rd_gnt),
      .eng_rd_gnt(eng_rd_gnt), .stall(stall), .rd_burst_done(rd_burst_done));
   //==========================================================================
   // clock and hang guard
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         final_report();
      end
   end
   //==========================================================================
   // shared tasks
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [11:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rchk(string nm, logic [11:0] a, logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(nm, e, d);
   endtask
   task automatic cycles(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // block code of one transaction id: lowest enabled rings, next engine
   function automatic logic [7:0] bid(int i);
      int k = 0;
      for (int j = 0; j < i; j++) k += int'(id_enable_pin[j]);
      if (!id_enable_pin[i] || k > 1) return 8'h00;
      return (k == 0) ? 8'h01 : 8'h08;
   endfunction
   function automatic logic [31:0] mapw(int b);
      return {bid(b + 3), bid(b + 2), bid(b + 1), bid(b)};
   endfunction
   // lowest enabled transaction id above a floor, sixteen when none
   function automatic int lowid(int above);
      for (int j = 0; j < 16; j++)
         if (id_enable_pin[j] && j > above) return j;
      return 16;
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   //==========================================================================
   // main sequence
   initial
   begin
      void'($urandom(37));
      id_enable_pin = 16'($urandom) | 16'h0100;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      cycles(4);
      // reset values, ring bases, reserved bits, unmapped place
      for (int r = 0; r < 3; r++) rchk("smb_rst", ADR[r], 32'h0010_0000);
      rchk("unmapped", 12'h128, 32'h0);
      for (int r = 0; r < 3; r++) smb[r] = $urandom & 32'h0000_ffff;
      for (int r = 0; r < 3; r++) wr(ADR[r], smb[r]);
      for (int r = 0; r < 3; r++) rchk("smb", ADR[r], smb[r]);
      wr(12'h220, 32'hffff_ff82);
      rchk("limit", 12'h220, 32'h0000_0002);
      $display("test registers done");
      // steering at the window edges of each ring
      for (int r = 0; r < 3; r++)
         for (int t = 0; t < 4; t++)
         begin
            @(posedge ref_clk);
            dma_req <= '{1'b1, 2'(r), {smb[r][31:0], 16'h0} + (t == 0 ? 48'h0 :
               t == 1 ? 48'h7fff : t == 2 ? 48'h8000 : 48'hffff_ffff_ffff)};
            @(posedge ref_clk);
            dma_req <= '0;
            #1 chk("steer", {31'h0, t < 2}, {31'h0, dma_to_secure});
            chk("steer_valid", 32'h1, {31'h0, dma_steer_valid});
         end
      $display("test steering done");
      // soft reset pulse and status write back
      wr(12'h124, 32'hffff_ffff);
      #1 chk("srst_pulse", 32'h1, {31'h0, eng_soft_rst});
      chk("status", 32'h120, {23'h0, eng_status});
      cycles(1);
      chk("srst_clear", 32'h0, {30'h0, eng_soft_rst, eng_status.valid});
      rchk("srst_read", 12'h124, 32'h0);
      // full reset as the fallback when a soft reset fails, then restore the limit
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      cycles(4);
      rchk("full_rst", ADR[0], 32'h0010_0000);
      rchk("limit_rst", 12'h220, 32'h0);
      wr(12'h220, 32'hffff_ff82);
      $display("test soft reset done");
      // poll bit, then halt: writes ignored, read shows stopped state
      wr(12'h120, 32'h1);
      rchk("poll_set", 12'h120, 32'h1);
      @(posedge ref_clk);
      eng_available <= 1'b1;
      cycles(2);
      rchk("poll_clr", 12'h120, 32'h0);
      @(posedge ref_clk);
      eng_available <= 1'b0;
      dbg_halt_req <= 1'b1;
      wr(12'h120, 32'h1);
      rchk("halt_run", 12'h120, 32'h0);
      chk("ack_wait", 32'h0, {31'h0, dbg_halt_ack});
      @(posedge ref_clk);
      eng_stopped <= 1'b1;
      cycles(2);
      chk("ack", 32'h1, {31'h0, dbg_halt_ack});
      rchk("halt_stop", 12'h120, 32'h1);
      @(posedge ref_clk);
      dbg_halt_req <= 1'b0;
      eng_stopped <= 1'b0;
      rchk("poll_ign", 12'h120, 32'h0);
      $display("test poll and halt done");
      // hardwired enables and id map at both aliases
      rchk("id_en", 12'h250, {16'h0, id_enable_pin});
      for (int b = 0; b < 16; b += 4)
      begin
         rchk("map", 12'h240 + (b == 0 ? 12'h4 : b == 4 ? 12'h0 : b == 8 ? 12'hc : 12'h8),
            mapw(b));
         rchk("map_alias", 12'h500 + (b == 0 ? 12'h4 : b == 4 ? 12'h0 : b == 8 ? 12'hc :
            12'h8), mapw(b));
      end
      chk("jr_id", 32'(lowid(-1) % 16), {28'h0, jr_txn_id});
      chk("eng_id", 32'(lowid(lowid(-1)) % 16), {28'h0, eng_txn_id});
      $display("test id map done");
      // throttle limit two with the far side stalled
      @(posedge ref_clk);
      stall <= 1'b1;
      jr_rd_req <= 1'b1;
      cycles(20);
      chk("throttled", 32'h1, {31'h0, jr_throttled});
      chk("jr_held", 32'h0, {31'h0, jr_rd_gnt});
      @(posedge ref_clk);
      eng_rd_req <= 1'b1;
      cycles(2);
      chk("eng_gnt", 32'h1, {31'h0, eng_rd_gnt});
      @(posedge ref_clk);
      eng_rd_req <= 1'b0;
      stall <= 1'b0;
      for (int i = 0; i < 200 && jr_rd_gnt !== 1'b1; i++) cycles(1);
      chk("resume", 32'h1, {31'h0, jr_rd_gnt});
      chk("unthrottled", 32'h0, {31'h0, jr_throttled});
      // limit zero never holds job rings back
      wr(12'h220, 32'h0);
      stall <= 1'b1;
      cycles(20);
      chk("no_smooth", 32'h3, {30'h0, jr_rd_gnt, !jr_throttled});
      @(posedge ref_clk);
      jr_rd_req <= 1'b0;
      stall <= 1'b0;
      cycles(4);
      $display("test throttle done");
      final_report();
   end
endmodule
